//--- pwmcac_pkg.sv
// Shared constants, register map and types of the PWM channel core.
package pwmcac_pkg;

  // Sizes of the channel array and of its data paths.
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 4;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Address type, used to place per-channel registers.
  typedef logic [ADDR_W-1:0] pwmcac_addr_t;

  // Register byte offsets on the APB side.
  localparam pwmcac_addr_t OFS_ENABLE = 8'h00;
  localparam pwmcac_addr_t OFS_POLARITY = 8'h04;
  localparam pwmcac_addr_t OFS_CLK_CHOICE = 8'h08;
  localparam pwmcac_addr_t OFS_ALIGN = 8'h0C;
  localparam pwmcac_addr_t OFS_PAIR_CTRL = 8'h10;
  localparam pwmcac_addr_t OFS_PERIOD = 8'h20;
  localparam pwmcac_addr_t OFS_DUTY = 8'h40;
  localparam pwmcac_addr_t OFS_COUNTER = 8'h60;
  localparam pwmcac_addr_t CH_STRIDE = 8'h04;

  // Reset values of the registers.
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [NUM_PAIR-1:0] RST_PAIR = 4'h0;
  localparam logic [BYTE_W-1:0] RST_PERIOD = 8'h00;
  localparam logic [BYTE_W-1:0] RST_DUTY = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // Counter constants.
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W:0] CNT_STEP = 17'h0_0001;

  // Counting direction of a channel counter.
  typedef enum logic {
    pwmcac_dir_up = 1'b0,
    pwmcac_dir_down = 1'b1
  } pwmcac_dir_t;

  // Settings that one counter engine works from.
  typedef struct packed {
    logic enable;
    logic center;
    logic pol;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
  } pwmcac_cfg_t;

  // Channel-wide control bits held by software.
  typedef struct packed {
    logic [BYTE_W-1:0] enable;
    logic [BYTE_W-1:0] polarity;
    logic [BYTE_W-1:0] choice;
    logic [BYTE_W-1:0] align;
    logic [NUM_PAIR-1:0] pair_join;
  } pwmcac_ctrl_t;

endpackage

//--- pwmcac_engine.sv
// One counter engine: counter, direction, active period and duty, waveform.
`timescale 1ns/100ps
module pwmcac_engine (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Channel clock tick and counter write strobe.
  input wire logic tick,
  input wire logic cnt_wr,
  // Buffered settings.
  input wire pwmcac_pkg::pwmcac_cfg_t cfg,
  // Engine state.
  output logic [pwmcac_pkg::CNT_W-1:0] count,
  output logic wave
);

  logic [pwmcac_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [pwmcac_pkg::CNT_W-1:0] per_q, per_d;
  logic [pwmcac_pkg::CNT_W-1:0] duty_q, duty_d;
  pwmcac_pkg::pwmcac_dir_t dir_q, dir_d;
  logic [pwmcac_pkg::CNT_W:0] cnt_inc;

  assign cnt_inc = {1'b0, cnt_q} + pwmcac_pkg::CNT_STEP;

  // Next counter state; a disabled channel keeps its count but lets the
  // buffers straight through, so new settings apply when it restarts.
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    per_d = per_q;
    duty_d = duty_q;
    if (!cfg.enable) begin
      per_d = cfg.period;
      duty_d = cfg.duty;
    end
    if (cnt_wr) begin
      cnt_d = pwmcac_pkg::CNT_ZERO;
      dir_d = pwmcac_pkg::pwmcac_dir_up;
      per_d = cfg.period;
      duty_d = cfg.duty;
    end else if (tick) begin
      if (per_q == pwmcac_pkg::CNT_ZERO) begin
        cnt_d = pwmcac_pkg::CNT_ZERO;
        dir_d = pwmcac_pkg::pwmcac_dir_up;
        per_d = cfg.period;
        duty_d = cfg.duty;
      end else if (cfg.enable && !cfg.center) begin
        if (cnt_inc >= {1'b0, per_q}) begin
          cnt_d = pwmcac_pkg::CNT_ZERO;
          per_d = cfg.period;
          duty_d = cfg.duty;
        end else begin
          cnt_d = cnt_inc[pwmcac_pkg::CNT_W-1:0];
        end
      end else if (cfg.enable && dir_q == pwmcac_pkg::pwmcac_dir_up) begin
        cnt_d = cnt_inc[pwmcac_pkg::CNT_W-1:0];
        if (cnt_inc >= {1'b0, per_q}) begin
          dir_d = pwmcac_pkg::pwmcac_dir_down;
        end
      end else if (cfg.enable) begin
        cnt_d = cnt_q - pwmcac_pkg::CNT_STEP[pwmcac_pkg::CNT_W-1:0];
        if (cnt_q <= pwmcac_pkg::CNT_STEP[pwmcac_pkg::CNT_W-1:0]) begin
          cnt_d = pwmcac_pkg::CNT_ZERO;
          dir_d = pwmcac_pkg::pwmcac_dir_up;
          per_d = cfg.period;
          duty_d = cfg.duty;
        end
      end
    end
    if (cnt_d == pwmcac_pkg::CNT_ZERO) begin
      dir_d = pwmcac_pkg::pwmcac_dir_up;
    end
  end

  // Counter registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= pwmcac_pkg::CNT_ZERO;
      dir_q <= pwmcac_pkg::pwmcac_dir_up;
      per_q <= pwmcac_pkg::CNT_ZERO;
      duty_q <= pwmcac_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      per_q <= per_d;
      duty_q <= duty_d;
    end
  end

  // Waveform level; counting down the duty match is inclusive, which gives
  // the second toggle of a center-aligned cycle at the same count.
  always_comb begin
    if (per_q == pwmcac_pkg::CNT_ZERO || duty_q >= per_q) begin
      wave = cfg.pol;
    end else if (dir_q == pwmcac_pkg::pwmcac_dir_down) begin
      wave = (cnt_q <= duty_q) ? cfg.pol : !cfg.pol;
    end else begin
      wave = (cnt_q < duty_q) ? cfg.pol : !cfg.pol;
    end
  end

  assign count = cnt_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  ctr_write_a: assert property (cnt_wr |=> cnt_q == '0 &&
    dir_q == pwmcac_pkg::pwmcac_dir_up && per_q == $past(cfg.period))
    else $error("counter write did not restart the channel");
  zero_per_a: assert property (tick && !cnt_wr && per_q == '0
    |=> cnt_q == '0) else $error("counter moved with zero period");
  left_wrap_a: assert property (tick && !cnt_wr && cfg.enable &&
    !cfg.center && per_q != '0 && cnt_inc >= {1'b0, per_q}
    |=> cnt_q == '0 && duty_q == $past(cfg.duty))
    else $error("left aligned period end missed");
  center_turn_a: assert property (tick && !cnt_wr && cfg.enable &&
    cfg.center && dir_q == pwmcac_pkg::pwmcac_dir_up && per_q != '0 &&
    cnt_inc == {1'b0, per_q} |=> dir_q == pwmcac_pkg::pwmcac_dir_down &&
    cnt_q == $past(per_q)) else $error("center turn at period missed");
  center_bottom_a: assert property (tick && !cnt_wr && cfg.enable &&
    cfg.center && dir_q == pwmcac_pkg::pwmcac_dir_down && per_q != '0 &&
    cnt_q == 16'h0001 |=> cnt_q == '0 && per_q == $past(cfg.period))
    else $error("center bottom reload missed");
  dir_zero_a: assert property (cnt_q == '0 |->
    dir_q == pwmcac_pkg::pwmcac_dir_up) else $error("down at zero");
  wave_start_a: assert property (cnt_q == '0 && duty_q != '0 &&
    duty_q < per_q |-> wave == cfg.pol) else $error("bad start level");

endmodule

//--- pwmcac_top.sv
// Eight-channel PWM output core with pair joining and an APB register file.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module pwmcac_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwmcac_pkg::ADDR_W-1:0] paddr,
  input wire logic [pwmcac_pkg::DATA_W-1:0] pwdata,
  output logic [pwmcac_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Prescaled clock ticks, one core_clk cycle wide.
  input wire logic clock_a_tick,
  input wire logic clock_b_tick,
  input wire logic scaled_clock_a,
  input wire logic scaled_clock_b,
  // Modulated outputs; bit 7 is channel_seven_output.
  output logic [pwmcac_pkg::NUM_CH-1:0] pwm_out
);

  // Software controls and buffered values.
  pwmcac_pkg::pwmcac_ctrl_t ctrl_q, ctrl_d;
  logic [pwmcac_pkg::BYTE_W-1:0] period_value_q [pwmcac_pkg::NUM_CH];
  logic [pwmcac_pkg::BYTE_W-1:0] period_value_d [pwmcac_pkg::NUM_CH];
  logic [pwmcac_pkg::BYTE_W-1:0] duty_value_q [pwmcac_pkg::NUM_CH];
  logic [pwmcac_pkg::BYTE_W-1:0] duty_value_d [pwmcac_pkg::NUM_CH];

  // Bus handshake and read-back registers.
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [pwmcac_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic [pwmcac_pkg::NUM_CH-1:0] pwm_out_q, pwm_out_d;

  // Decode results and per-channel engine wiring.
  logic acc_fire, wr_fire;
  logic [pwmcac_pkg::NUM_CH-1:0] hit_per, hit_duty, hit_cnt;
  logic [pwmcac_pkg::NUM_CH-1:0] cnt_wr, eng_tick, eng_en, wave;
  logic [pwmcac_pkg::BYTE_W-1:0] cnt_byte [pwmcac_pkg::NUM_CH];
  logic [pwmcac_pkg::CNT_W-1:0] eng_count [pwmcac_pkg::NUM_CH];
  logic [pwmcac_pkg::DATA_W-1:0] rd_data;
  logic rd_hit;

  // A request completes at the edge where pready is seen high, so the
  // access phase lasts two cycles; writes act only at that edge.
  assign acc_fire = psel && penable && pready_q;
  assign wr_fire = acc_fire && pwrite;

  // Per-channel decode, setting mux, engine and output level.
  for (genvar k = 0; k < pwmcac_pkg::NUM_CH; k++) begin : g_ch
    localparam pwmcac_pkg::pwmcac_addr_t CH_OFS =
      pwmcac_pkg::CH_STRIDE * pwmcac_pkg::pwmcac_addr_t'(k);
    localparam int PAIR = k / 2;
    localparam int MATE = k ^ 1;
    localparam bit ODD = (k % 2) == 1;
    localparam bit GROUP_B = ((k / 2) % 2) == 1;
    logic joined;
    logic sel_scaled;
    pwmcac_pkg::pwmcac_cfg_t cfg;

    assign joined = ctrl_q.pair_join[PAIR];
    assign hit_per[k] = paddr == pwmcac_pkg::OFS_PERIOD + CH_OFS;
    assign hit_duty[k] = paddr == pwmcac_pkg::OFS_DUTY + CH_OFS;
    assign hit_cnt[k] = paddr == pwmcac_pkg::OFS_COUNTER + CH_OFS;

    // Each channel chooses its own clock, so a joined pair is driven by
    // the odd engine's choice without extra muxing.
    assign sel_scaled = ctrl_q.choice[k];
    if (GROUP_B) begin : g_clk_b
      assign eng_tick[k] = sel_scaled ? scaled_clock_b : clock_b_tick;
    end else begin : g_clk_a
      assign eng_tick[k] = sel_scaled ? scaled_clock_a : clock_a_tick;
    end

    // Settings: a joined odd engine sees even bytes on top.
    if (ODD) begin : g_odd
      always_comb begin
        cfg.enable = ctrl_q.enable[k];
        cfg.center = ctrl_q.align[k];
        cfg.pol = ctrl_q.polarity[k];
        if (joined) begin
          cfg.period = {period_value_q[MATE], period_value_q[k]};
          cfg.duty = {duty_value_q[MATE], duty_value_q[k]};
        end else begin
          cfg.period = {pwmcac_pkg::RST_BYTE, period_value_q[k]};
          cfg.duty = {pwmcac_pkg::RST_BYTE, duty_value_q[k]};
        end
      end
      // Either byte address of a joined pair restarts the whole counter.
      assign cnt_wr[k] = wr_fire &&
        (hit_cnt[k] || (joined && hit_cnt[MATE]));
      assign cnt_byte[k] = eng_count[k][pwmcac_pkg::BYTE_W-1:0];
    end else begin : g_even
      always_comb begin
        cfg.enable = ctrl_q.enable[k] && !joined;
        cfg.center = ctrl_q.align[k];
        cfg.pol = ctrl_q.polarity[k];
        cfg.period = {pwmcac_pkg::RST_BYTE, period_value_q[k]};
        cfg.duty = {pwmcac_pkg::RST_BYTE, duty_value_q[k]};
      end
      assign cnt_wr[k] = wr_fire && hit_cnt[k];
      // A joined even channel reads the high byte of the odd engine.
      assign cnt_byte[k] = joined ?
        eng_count[MATE][pwmcac_pkg::CNT_W-1:pwmcac_pkg::BYTE_W] :
        eng_count[k][pwmcac_pkg::BYTE_W-1:0];
    end

    assign eng_en[k] = cfg.enable;
    // A disabled channel, or the high half of a joined pair, drives low.
    assign pwm_out_d[k] = eng_en[k] && wave[k];

    pwmcac_engine u_engine (
      .core_clk(core_clk),
      .reset(reset),
      .tick(eng_tick[k]),
      .cnt_wr(cnt_wr[k]),
      .cfg(cfg),
      .count(eng_count[k]),
      .wave(wave[k])
    );

    if (!ODD) begin : g_pair_chk
      hi_out_off_a: assert property (
        @(posedge core_clk) disable iff (reset) joined |=> !pwm_out_q[k])
        else $error("high half of joined pair drives its pin");
      pair_cnt_rst_a: assert property (@(posedge core_clk)
        disable iff (reset) joined && cnt_wr[k] |=> !joined ||
        eng_count[MATE] == pwmcac_pkg::CNT_ZERO)
        else $error("joined counter not reset by high byte write");
      pair_clock_a: assert property (@(posedge core_clk)
        disable iff (reset) ctrl_q.enable[MATE] && !ctrl_q.align[MATE] &&
        !eng_tick[MATE] && !cnt_wr[MATE] && cfg.enable == 1'b0 && joined &&
        eng_count[MATE] != pwmcac_pkg::CNT_ZERO
        |=> $stable(eng_count[MATE]) || $past(eng_tick[MATE]))
        else $error("joined counter moved without odd clock");
    end
  end

  // Register next values; narrow registers take the low data bits.
  always_comb begin
    ctrl_d = ctrl_q;
    period_value_d = period_value_q;
    duty_value_d = duty_value_q;
    if (wr_fire) begin
      case (paddr)
        pwmcac_pkg::OFS_ENABLE: begin
          ctrl_d.enable = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
        pwmcac_pkg::OFS_POLARITY: begin
          ctrl_d.polarity = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
        pwmcac_pkg::OFS_CLK_CHOICE: begin
          ctrl_d.choice = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
        pwmcac_pkg::OFS_ALIGN: begin
          ctrl_d.align = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
        pwmcac_pkg::OFS_PAIR_CTRL: begin
          ctrl_d.pair_join = pwdata[pwmcac_pkg::NUM_PAIR-1:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
      for (int i = 0; i < pwmcac_pkg::NUM_CH; i++) begin
        if (hit_per[i]) begin
          period_value_d[i] = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
        if (hit_duty[i]) begin
          duty_value_d[i] = pwdata[pwmcac_pkg::BYTE_W-1:0];
        end
      end
    end
  end

  // Register file storage.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q.enable <= pwmcac_pkg::RST_BYTE;
      ctrl_q.polarity <= pwmcac_pkg::RST_BYTE;
      ctrl_q.choice <= pwmcac_pkg::RST_BYTE;
      ctrl_q.align <= pwmcac_pkg::RST_BYTE;
      ctrl_q.pair_join <= pwmcac_pkg::RST_PAIR;
      for (int i = 0; i < pwmcac_pkg::NUM_CH; i++) begin
        period_value_q[i] <= pwmcac_pkg::RST_PERIOD;
        duty_value_q[i] <= pwmcac_pkg::RST_DUTY;
      end
    end else begin
      ctrl_q <= ctrl_d;
      period_value_q <= period_value_d;
      duty_value_q <= duty_value_d;
    end
  end

  // Read multiplexer; counters read live without disturbing the count.
  always_comb begin
    rd_data = pwmcac_pkg::RD_ZERO;
    rd_hit = 1'b1;
    case (paddr)
      pwmcac_pkg::OFS_ENABLE: begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = ctrl_q.enable;
      end
      pwmcac_pkg::OFS_POLARITY: begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = ctrl_q.polarity;
      end
      pwmcac_pkg::OFS_CLK_CHOICE: begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = ctrl_q.choice;
      end
      pwmcac_pkg::OFS_ALIGN: begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = ctrl_q.align;
      end
      pwmcac_pkg::OFS_PAIR_CTRL: begin
        rd_data[pwmcac_pkg::NUM_PAIR-1:0] = ctrl_q.pair_join;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    for (int i = 0; i < pwmcac_pkg::NUM_CH; i++) begin
      if (hit_per[i]) begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = period_value_q[i];
        rd_hit = 1'b1;
      end
      if (hit_duty[i]) begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = duty_value_q[i];
        rd_hit = 1'b1;
      end
      if (hit_cnt[i]) begin
        rd_data[pwmcac_pkg::BYTE_W-1:0] = cnt_byte[i];
        rd_hit = 1'b1;
      end
    end
  end

  // Handshake next values; an unmapped address answers with an error
  // and reads as zero, and its write is dropped.
  always_comb begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !rd_hit;
    prdata_d = pwmcac_pkg::RD_ZERO;
    if (pready_d && !pwrite && rd_hit) begin
      prdata_d = rd_data;
    end
  end

  // Handshake and pin registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= pwmcac_pkg::RD_ZERO;
      pwm_out_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      pwm_out_q <= pwm_out_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_out = pwm_out_q;

  apb_ready_a: assert property (@(posedge core_clk) disable iff (reset)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("pready not a single pulse after access");
  cnt_wr_reset_a: assert property (@(posedge core_clk)
    disable iff (reset) cnt_wr[1] |=> eng_count[1] == pwmcac_pkg::CNT_ZERO)
    else $error("channel one counter write ignored");

  left_wrap_c: cover property (@(posedge core_clk) disable iff (reset)
    eng_en[2] && !ctrl_q.align[2] && eng_count[2] != '0 ##1
    eng_count[2] == '0);
  center_run_c: cover property (@(posedge core_clk) disable iff (reset)
    eng_en[2] && ctrl_q.align[2] && pwm_out_q[2] ##1 !pwm_out_q[2]);
  joined_run_c: cover property (@(posedge core_clk) disable iff (reset)
    ctrl_q.pair_join[0] && eng_en[1] && eng_count[1][pwmcac_pkg::BYTE_W]);

endmodule

//--- pwmcac_fix_placeholder.sv
// Spare source of the PWM channel core; it holds no logic.

//--- pwmcac_load.sv
// External load model that integrates the high time of one output pin.
`timescale 1ns/100ps
module pwmcac_load (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Observed pins and measurement request.
  input wire logic [7:0] pin,
  input wire logic [2:0] ch,
  input wire logic go,
  input wire logic [15:0] len,
  // Measurement result, done stands for one cycle.
  output logic done,
  output logic [15:0] hi_cnt
);
  logic [15:0] left_q;
  logic [15:0] left_d;
  logic [15:0] hi_d;
  logic done_d;

  // A window of whole periods gives an exact high count at any phase.
  always_comb begin
    left_d = left_q;
    hi_d = hi_cnt;
    done_d = 1'b0;
    if (go) begin
      left_d = len;
      hi_d = 16'h0000;
    end else if (left_q != 16'h0000) begin
      left_d = left_q - 16'h0001;
      hi_d = hi_cnt + {15'h0000, pin[ch]};
      done_d = (left_q == 16'h0001);
    end
  end

  // State registers of the load.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      left_q <= 16'h0000;
      hi_cnt <= 16'h0000;
      done <= 1'b0;
    end else begin
      left_q <= left_d;
      hi_cnt <= hi_d;
      done <= done_d;
    end
  end
endmodule

//--- pwm_channel_align_concat_test.sv
// Self-checking bench of the PWM channel core with scoreboard queues.
`timescale 1ns/100ps
module pwm_channel_align_concat_test;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, ld_go;
  logic ld_done;
  logic [7:0] paddr, pwm_out;
  logic [31:0] pwdata, prdata, sc_q, r;
  logic [1:0] tk_q;
  logic [2:0] ld_ch;
  logic [15:0] ld_len, hi_cnt;
  logic [33:0] rq[$];
  logic [15:0] hq[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int p, d, pol, c;

  pwmcac_top i_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_a_tick(tk_q[0]), .clock_b_tick(tk_q[1]),
    .scaled_clock_a(sc_q[3]), .scaled_clock_b(sc_q[9]), .pwm_out(pwm_out));
  pwmcac_load i_load (.core_clk(core_clk), .reset(reset), .pin(pwm_out),
    .ch(ld_ch), .go(ld_go), .len(ld_len), .done(ld_done), .hi_cnt(hi_cnt));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // High cycles in a window w of whole periods, boundary cases first.
  function automatic logic [15:0] hi(input int p, d, pol, w);
    if (p == 0 || d >= p) return 16'(pol * w);
    if (d == 0) return 16'((1 - pol) * w);
    return 16'(pol ? w * d / p : w * (p - d) / p);
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; psel stays up so a next setup may follow at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
      input logic [33:0] e);
    rq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the run limit ends this wait, so a hang fails the run.
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 34'h0_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0000_0000, {2'b10, v});
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic tick(input int s, input int n);
    tk_q[s] <= 1'b1;
    repeat (n) @(posedge core_clk);
    tk_q[s] <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic meas(input int ch, input int w, input logic [15:0] e);
    hq.push_back(e);
    ld_ch <= 3'(ch);
    ld_len <= 16'(w);
    ld_go <= 1'b1;
    @(posedge core_clk);
    ld_go <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (ld_done !== 1'b1);
  endtask

  // Free-running clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Random scaled ticks and the run limit.
  always @(posedge core_clk) begin
    sc_q <= xs(sc_q);
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end

  // Results appear at pready or at load done; oldest note is compared.
  always @(posedge core_clk) begin
    logic [33:0] e;
    if (pready === 1'b1) begin
      e = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
      check({pslverr, e[33] ? prdata : e[31:0]}, e[32:0]);
    end
    if (ld_done === 1'b1) begin
      e = (hq.size() > 0) ? {18'h0_0000, hq.pop_front()} : 34'h3_ffff_ffff;
      check({17'h0_0000, hi_cnt}, e[32:0]);
    end
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, ld_go} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tk_q = 2'b00;
    ld_ch = 3'h0;
    ld_len = 16'h0000;
    sc_q = 32'h3019_93a0;
    r = 32'h3019_93a0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(pwmcac_pkg::OFS_ENABLE, 32'h0000_0000);
    rd(pwmcac_pkg::OFS_PERIOD, 32'h0000_0000);
    rd(pwmcac_pkg::OFS_PAIR_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000, 34'h3_0000_0000);
    wr(pwmcac_pkg::OFS_POLARITY, 32'h0000_005A);
    rd(pwmcac_pkg::OFS_POLARITY, 32'h0000_005A);
    // Counter position after five ticks, left then center, channel 2.
    for (c = 0; c < 2; c++) begin
      wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0000);
      wr(pwmcac_pkg::OFS_PERIOD + 8'h08, 32'h0000_0004);
      wr(pwmcac_pkg::OFS_DUTY + 8'h08, 32'h0000_0001);
      wr(pwmcac_pkg::OFS_ALIGN, 32'(c << 2));
      wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0004);
      idle(1);
      tick(1, 2);
      wr(pwmcac_pkg::OFS_COUNTER + 8'h08, 32'h0000_00FF);
      idle(2);
      tick(1, 5);
      rd(pwmcac_pkg::OFS_COUNTER + 8'h08, c ? 32'h3 : 32'h1);
      idle(1);
    end
    // Waveform high time, random settings with forced boundary cases.
    tk_q[1] <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      r = xs(r);
      p = (i == 0) ? 0 : 1 + int'(r % 7);
      d = (i == 1) ? 0 : (i == 2) ? p : (i == 3) ? p + 1 : int'(r[11:4] % 9);
      pol = int'(r[16]);
      c = int'(r[17]);
      wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0000);
      wr(pwmcac_pkg::OFS_PERIOD + 8'h08, 32'(p));
      wr(pwmcac_pkg::OFS_DUTY + 8'h08, 32'(d));
      wr(pwmcac_pkg::OFS_POLARITY, 32'(pol << 2));
      wr(pwmcac_pkg::OFS_ALIGN, 32'(c << 2));
      wr(pwmcac_pkg::OFS_COUNTER + 8'h08, 32'h0000_0000);
      wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0004);
      idle(20);
      meas(2, 840, hi(p, d, pol, 840));
    end
    // Joined pair 0/1: even enable, align, polarity and clock choice must be ignored; even bytes are the high halves.
    wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0000);
    wr(pwmcac_pkg::OFS_PAIR_CTRL, 32'h0000_0001);
    wr(pwmcac_pkg::OFS_PERIOD, 32'h0000_0001);
    wr(pwmcac_pkg::OFS_PERIOD + 8'h04, 32'h0000_0002);
    wr(pwmcac_pkg::OFS_DUTY, 32'h0000_0000);
    wr(pwmcac_pkg::OFS_DUTY + 8'h04, 32'h0000_0081);
    wr(pwmcac_pkg::OFS_POLARITY, 32'h0000_0002);
    wr(pwmcac_pkg::OFS_ALIGN, 32'h0000_0001);
    wr(pwmcac_pkg::OFS_CLK_CHOICE, 32'h0000_0001);
    wr(pwmcac_pkg::OFS_ENABLE, 32'h0000_0003);
    idle(1);
    tick(0, 2);
    wr(pwmcac_pkg::OFS_COUNTER, 32'h0000_0000);
    idle(2);
    tick(0, 300);
    rd(pwmcac_pkg::OFS_COUNTER, 32'h0000_0000);
    rd(pwmcac_pkg::OFS_COUNTER + 8'h04, 32'h0000_002A);
    idle(1);
    tk_q[0] <= 1'b1;
    idle(20);
    meas(1, 516, hi(258, 129, 1, 516));
    meas(0, 516, 16'h0000);
    idle(2);
    results();
  end
endmodule
